//--- pio_pkg.sv
// Purpose: Shared constants for the pin and converter register bank
// Assumes: Byte-wide register access at printed offsets
// Notes: Result registers sit at 10h..1Fh, one per converter channel slot
package pio_pkg;
   localparam logic [7:0] PIO_ADDR_PIN_CTRL = 8'h06;
   localparam logic [7:0] PIO_ADDR_CHAN_SEL = 8'h07;
   localparam logic [7:0] PIO_ADDR_RESULT_BASE = 8'h10;
   localparam logic [7:0] PIO_ADDR_RESULT_LAST = 8'h1f;
   localparam logic [7:0] PIO_ADDR_FAULT2 = 8'h05;
   localparam int PIO_ROUTE_MSB = 7;
   localparam int PIO_ROUTE_LSB = 6;
   localparam int PIO_OUT_LSB = 3;
   localparam int PIO_IN_LSB = 0;
   localparam int PIO_CHANGE_BIT = 7;
   localparam logic [1:0] PIO_ROUTE_RESET = 2'h0;
   localparam logic [2:0] PIO_OUT_RESET = 3'h7;
   localparam logic [3:0] PIO_CHAN_RESET = 4'h0;
   localparam logic [3:0] PIO_CHAN_PIN = 4'hc;
   localparam logic [7:0] PIO_RESULT_RESET = 8'h00;
   // Conversion time of one on-demand measurement
   localparam int PIO_CONV_TIME_NS = 1000;
   localparam int PIO_CLK_PERIOD_NS = 10;
   localparam int PIO_CONV_CYCLES = (PIO_CONV_TIME_NS + PIO_CLK_PERIOD_NS - 1) / PIO_CLK_PERIOD_NS;
   localparam int PIO_NUM_RESULTS = 16;
   typedef enum logic [1:0] {
      PIO_IDLE = 2'b00,
      PIO_CONVERT = 2'b01,
      PIO_STORE = 2'b10
   } pio_conv_state_type;
endpackage : pio_pkg

//--- pio_pin_cell.sv
// Purpose: One general pin: open-drain drive and level report
// Assumes: Pin level input is synchronous to clk
// Notes: Absent pins read low and never drive
`timescale 1ns/1ps
module pio_pin_cell
   import pio_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic present,
   input wire logic out_bit,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_n,
   output logic level
);
   assign pin_out = 1'b0;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_oe_n <= 1'b1;
         level <= 1'b0;
      end else begin
         pin_oe_n <= !(present && !out_bit);
         level <= present && pin_in;
      end
   end
endmodule : pio_pin_cell

//--- pio_converter.sv
// Purpose: Timed on-demand conversion sequencer
// Assumes: Analog sample arrives on sample_code when the conversion ends
// Notes: A new start during a conversion restarts it on the new channel
`timescale 1ns/1ps
module pio_converter
   import pio_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   output logic busy,
   output logic done
);
   pio_conv_state_type state;
   logic [15:0] count;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= PIO_IDLE;
         count <= 16'h0000;
      end else if (start) begin
         state <= PIO_CONVERT;
         count <= 16'(PIO_CONV_CYCLES - 1);
      end else begin
         unique case (state)
            PIO_IDLE: begin
               count <= 16'h0000;
            end
            PIO_CONVERT: begin
               if (count == 16'h0000) begin
                  state <= PIO_STORE;
               end else begin
                  count <= count - 16'h0001;
               end
            end
            PIO_STORE: begin
               state <= PIO_IDLE;
            end
            default: begin
               state <= PIO_IDLE;
            end
         endcase
      end
   end
   assign busy = (state != PIO_IDLE);
   assign done = (state == PIO_STORE);
endmodule : pio_converter

//--- pio_regs.sv
// Purpose: Pin control, channel select, change flag and result registers
// Assumes: Serial bus decoder delivers one-cycle byte read and write strobes
// Notes: Read data is registered, valid the cycle after rd_en
`timescale 1ns/1ps
// Functional notes
// - Bits 7:6 route pin one (00,01), two (10) or three (11) to converter.
// - Bits 5:3 drive pins three..one open-drain; 1 releases, 0 pulls low.
// - Bits 2:0 read present levels of pins three..one.
// - Pins two and three act only in the larger package.
// - Channel register bits 3:0 pick on-demand channel; bits 7:4 unused.
// - Codes 0..11 pick supply measurements in order; 11xx picks pin voltage.
// - Results live at 10h..1Fh, eight bits each, readable and writable.
// - 12V input and output results use 55mV steps, 14.025V full scale.
// - 12V sense result uses 250uV steps, 63.75mV full scale.
// - 5V input uses 22mV steps, or 15mV when rail is set to 3.3V.
// - Pin one changing level sets a sticky flag, fault register bit 7.
module pio_regs
   import pio_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic large_package,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe_n,
   output logic [1:0] pin_route,
   output logic [3:0] conv_channel,
   input wire logic [7:0] sample_code,
   output logic conv_busy
);
   logic [1:0] route;
   logic [2:0] out_bits;
   logic [2:0] levels;
   logic [3:0] chan;
   logic pin_one_changed;
   logic pin_one_last;
   logic level_valid;
   logic conv_start;
   logic conv_done;
   logic [7:0] results [PIO_NUM_RESULTS];
   logic [3:0] result_index;
   logic [7:0] next_rd_data;
   logic level_primed;
   logic [7:0] conv_age;
   logic addr_mapped;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pin
         pio_pin_cell u_cell (
            .clk(clk),
            .reset_n(reset_n),
            .present((g == 0) ? 1'b1 : large_package),
            .out_bit(out_bits[g]),
            .pin_in(pin_in[g]),
            .pin_out(pin_out[g]),
            .pin_oe_n(pin_oe_n[g]),
            .level(levels[g])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         route <= PIO_ROUTE_RESET;
         out_bits <= PIO_OUT_RESET;
      end else if (wr_en && addr == PIO_ADDR_PIN_CTRL) begin
         route <= wr_data[PIO_ROUTE_MSB:PIO_ROUTE_LSB];
         out_bits <= wr_data[PIO_OUT_LSB +: 3];
      end
   end

   // Codes 00 and 01 both land on pin one
   assign pin_route = (route == 2'h3) ? 2'h2 : (route == 2'h2) ? 2'h1 : 2'h0;

   assign conv_start = wr_en && addr == PIO_ADDR_CHAN_SEL;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chan <= PIO_CHAN_RESET;
      end else if (conv_start) begin
         chan <= wr_data[3:0];
      end
   end
   assign conv_channel = chan;

   pio_converter u_conv (
      .clk(clk),
      .reset_n(reset_n),
      .start(conv_start),
      .busy(conv_busy),
      .done(conv_done)
   );

   // Pin-voltage codes 11xx all share slot 12
   assign result_index = (chan[3:2] == 2'h3) ? PIO_CHAN_PIN : chan;

   // Scaling of each slot is fixed by the analog front end; codes are stored raw
   generate
      for (g = 0; g < PIO_NUM_RESULTS; g++) begin : g_res
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               results[g] <= PIO_RESULT_RESET;
            end else if (wr_en && addr == PIO_ADDR_RESULT_BASE + 8'(g)) begin
               results[g] <= wr_data;
            end else if (conv_done && result_index == 4'(g)) begin
               results[g] <= sample_code;
            end
         end
      end
   endgenerate

   // Both samples must hold real pin levels first, else the pulled-up idle pin reads as a change
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_one_last <= 1'b0;
         level_primed <= 1'b0;
         level_valid <= 1'b0;
      end else begin
         pin_one_last <= levels[0];
         level_primed <= 1'b1;
         level_valid <= level_primed;
      end
   end

   // Set wins over a clearing write in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_one_changed <= 1'b0;
      end else if (level_valid && levels[0] != pin_one_last) begin
         pin_one_changed <= 1'b1;
      end else if (wr_en && addr == PIO_ADDR_FAULT2) begin
         pin_one_changed <= wr_data[PIO_CHANGE_BIT];
      end
   end

   assign addr_mapped = addr == PIO_ADDR_FAULT2 || addr == PIO_ADDR_PIN_CTRL
      || addr == PIO_ADDR_CHAN_SEL
      || (addr >= PIO_ADDR_RESULT_BASE && addr <= PIO_ADDR_RESULT_LAST);

   always_comb begin
      next_rd_data = 8'h00;
      if (addr == PIO_ADDR_PIN_CTRL) begin
         next_rd_data = {route, out_bits, levels};
      end else if (addr == PIO_ADDR_CHAN_SEL) begin
         next_rd_data = {4'h0, chan};
      end else if (addr == PIO_ADDR_FAULT2) begin
         next_rd_data = {pin_one_changed, 7'h00};
      end else if (addr >= PIO_ADDR_RESULT_BASE && addr <= PIO_ADDR_RESULT_LAST) begin
         next_rd_data = results[addr[3:0]];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= next_rd_data;
      end
   end

   property p_route_write;
      @(posedge clk) disable iff (!reset_n)
      (wr_en && addr == PIO_ADDR_PIN_CTRL) |=> route == $past(wr_data[7:6]);
   endproperty
   a_route_write: assert property (p_route_write) else $error("route not stored");

   property p_route_map;
      @(posedge clk) disable iff (!reset_n)
      route[1] == 1'b0 |-> pin_route == 2'h0;
   endproperty
   a_route_map: assert property (p_route_map) else $error("low codes must pick pin one");

   property p_drive;
      @(posedge clk) disable iff (!reset_n)
      ##1 !out_bits[0] |=> !pin_oe_n[0];
   endproperty
   a_drive: assert property (p_drive) else $error("pin one not pulled low");

   property p_level;
      @(posedge clk) disable iff (!reset_n)
      1'b1 |=> levels[0] == $past(pin_in[0]);
   endproperty
   a_level: assert property (p_level) else $error("pin one level wrong");

   property p_absent;
      @(posedge clk) disable iff (!reset_n)
      !large_package [*2] |-> pin_oe_n[2:1] == 2'h3 && levels[2:1] == 2'h0;
   endproperty
   a_absent: assert property (p_absent) else $error("absent pin active");

   property p_reserved;
      @(posedge clk) disable iff (!reset_n)
      (rd_en && addr == PIO_ADDR_CHAN_SEL) |=> rd_data[7:4] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

   property p_conv_store;
      @(posedge clk) disable iff (!reset_n)
      conv_done && !wr_en |=> results[$past(result_index)] == $past(sample_code);
   endproperty
   a_conv_store: assert property (p_conv_store) else $error("result not stored");

   // Busy cycles since the last start; saturates so a hang stays visible
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conv_age <= 8'h00;
      end else if (conv_start) begin
         conv_age <= 8'h00;
      end else if (conv_busy && conv_age != 8'hff) begin
         conv_age <= conv_age + 8'h01;
      end
   end

   property p_conv_ends;
      @(posedge clk) disable iff (!reset_n)
      conv_busy |-> conv_age <= 8'(PIO_CONV_CYCLES);
   endproperty
   a_conv_ends: assert property (p_conv_ends) else $error("conversion hung");

   property p_change;
      @(posedge clk) disable iff (!reset_n)
      level_valid && levels[0] != pin_one_last |=> pin_one_changed;
   endproperty
   a_change: assert property (p_change) else $error("change flag missed");

   property p_out_write;
      @(posedge clk) disable iff (!reset_n)
      (wr_en && addr == PIO_ADDR_PIN_CTRL) |=> out_bits == $past(wr_data[5:3]);
   endproperty
   a_out_write: assert property (p_out_write) else $error("outputs not stored");

   property p_ctrl_hold;
      @(posedge clk) disable iff (!reset_n)
      !(wr_en && addr == PIO_ADDR_PIN_CTRL) |=> $stable(route) && $stable(out_bits);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("pin control moved");

   property p_route_high;
      @(posedge clk) disable iff (!reset_n)
      route[1] |-> pin_route == (route[0] ? 2'h2 : 2'h1);
   endproperty
   a_route_high: assert property (p_route_high) else $error("high codes misrouted");

   property p_release;
      @(posedge clk) disable iff (!reset_n)
      out_bits[0] |=> pin_oe_n[0];
   endproperty
   a_release: assert property (p_release) else $error("pin one not released");

   property p_drive_large;
      @(posedge clk) disable iff (!reset_n)
      large_package && !out_bits[2] |=> !pin_oe_n[2];
   endproperty
   a_drive_large: assert property (p_drive_large) else $error("pin three not low");

   property p_level_large;
      @(posedge clk) disable iff (!reset_n)
      large_package |=> levels[2:1] == $past(pin_in[2:1]);
   endproperty
   a_level_large: assert property (p_level_large) else $error("upper levels wrong");

   property p_ctrl_read;
      @(posedge clk) disable iff (!reset_n)
      (rd_en && addr == PIO_ADDR_PIN_CTRL) |=> rd_data == $past({route, out_bits, levels});
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("pin read wrong");

   property p_chan_write;
      @(posedge clk) disable iff (!reset_n)
      conv_start |=> chan == $past(wr_data[3:0]);
   endproperty
   a_chan_write: assert property (p_chan_write) else $error("channel not stored");

   property p_chan_hold;
      @(posedge clk) disable iff (!reset_n)
      !conv_start |=> $stable(chan);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel moved");

   property p_unmapped;
      @(posedge clk) disable iff (!reset_n)
      (rd_en && !addr_mapped) |=> rd_data == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

   property p_result_write;
      @(posedge clk) disable iff (!reset_n)
      (wr_en && addr[7:4] == 4'h1) |=> results[$past(addr[3:0])] == $past(wr_data);
   endproperty
   a_result_write: assert property (p_result_write) else $error("result write lost");

   property p_flag_sticky;
      @(posedge clk) disable iff (!reset_n)
      pin_one_changed && !(wr_en && addr == PIO_ADDR_FAULT2) |=> pin_one_changed;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("change flag lost");

   property p_busy_start;
      @(posedge clk) disable iff (!reset_n)
      conv_start |=> conv_busy;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("conversion not begun");

   c_conv: cover property (@(posedge clk) disable iff (!reset_n) conv_done);
   c_pin_drive: cover property (@(posedge clk) disable iff (!reset_n) !pin_oe_n[2]);
   c_change: cover property (@(posedge clk) disable iff (!reset_n) $rose(pin_one_changed));
   c_route_three: cover property (@(posedge clk) disable iff (!reset_n) pin_route == 2'h2);
   c_absent: cover property (@(posedge clk) disable iff (!reset_n) !large_package && !pin_oe_n[0]);
endmodule : pio_regs

//--- test_pin_io_and_adc_select_registers.sv
// Purpose: Self-checking bench for the pin control and converter select registers
// Assumes: Pins have external pull-ups; the bench resolves each wire from pin_oe_n
// Notes: Inputs change on the falling edge; conversions wait under a bounded count
`timescale 1ns/1ps
module test_pin_io_and_adc_select_registers;
   import pio_pkg::*;
   logic clk, reset_n, large_package, wr_en, rd_en, conv_busy;
   logic [7:0] addr, wr_data, rd_data, sample_code, q;
   logic [2:0] ext, pin_in, pin_out, pin_oe_n;
   logic [1:0] pin_route;
   logic [3:0] conv_channel;
   int error_cnt, checks_done;

   // Open-drain wire: pulled low while the block enables its driver
   assign pin_in = ext & pin_oe_n;

   pio_regs pio_regs_i (.clk(clk), .reset_n(reset_n), .large_package(large_package),
      .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_route(pin_route),
      .conv_channel(conv_channel), .sample_code(sample_code), .conv_busy(conv_busy));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      d = rd_data;
   endtask : rd

   task automatic t_reset();
      rd(PIO_ADDR_PIN_CTRL, q);
      cmp(q, 8'h3f);
      cmp({6'h00, pin_route}, 8'h00);
      cmp({5'h00, pin_oe_n}, 8'h07);
      rd(PIO_ADDR_CHAN_SEL, q);
      cmp(q, 8'h00);
      rd(8'h08, q);
      cmp(q, 8'h00);
      rd(PIO_ADDR_FAULT2, q);
      cmp(q, 8'h00);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_route();
      logic [1:0] exp [4];
      exp = '{2'h0, 2'h0, 2'h1, 2'h2};
      for (int i = 0; i < 4; i++) begin
         wr(PIO_ADDR_PIN_CTRL, {i[1:0], 6'h38});
         repeat (2) @(negedge clk);
         cmp({6'h00, pin_route}, {6'h00, exp[i]});
         rd(PIO_ADDR_PIN_CTRL, q);
         cmp(q, {i[1:0], 6'h3f});
      end
      $display("t_route done");
   endtask : t_route

   task automatic t_drive();
      // Ones written to the level bits must not reach the register
      wr(PIO_ADDR_PIN_CTRL, 8'h07);
      repeat (3) @(negedge clk);
      cmp({5'h00, pin_oe_n}, 8'h00);
      cmp({5'h00, pin_out}, 8'h00);
      rd(PIO_ADDR_PIN_CTRL, q);
      cmp(q, 8'h00);
      wr(PIO_ADDR_PIN_CTRL, 8'h28);
      repeat (3) @(negedge clk);
      cmp({5'h00, pin_oe_n}, 8'h05);
      rd(PIO_ADDR_PIN_CTRL, q);
      cmp(q, 8'h2d);
      large_package = 1'b0;
      wr(PIO_ADDR_PIN_CTRL, 8'h00);
      repeat (3) @(negedge clk);
      cmp({5'h00, pin_oe_n}, 8'h06);
      wr(PIO_ADDR_PIN_CTRL, 8'h38);
      repeat (3) @(negedge clk);
      rd(PIO_ADDR_PIN_CTRL, q);
      cmp(q, 8'h39);
      large_package = 1'b1;
      $display("t_drive done");
   endtask : t_drive

   task automatic t_level();
      logic [2:0] pat [2];
      pat = '{3'h5, 3'h2};
      for (int i = 0; i < 2; i++) begin
         ext = pat[i];
         repeat (3) @(negedge clk);
         rd(PIO_ADDR_PIN_CTRL, q);
         cmp(q, {5'h07, pat[i]});
      end
      ext = 3'h7;
      $display("t_level done");
   endtask : t_level

   task automatic t_conv();
      logic [3:0] code [3];
      logic [7:0] slot [3];
      int n;
      code = '{4'h0, 4'h3, 4'hd};
      slot = '{8'h10, 8'h13, 8'h1c};
      for (int i = 0; i < 3; i++) begin
         sample_code = 8'ha0 + 8'(i);
         wr(PIO_ADDR_CHAN_SEL, {4'hf, code[i]});
         cmp({4'h0, conv_channel}, {4'h0, code[i]});
         cmp({7'h00, conv_busy}, 8'h01);
         n = 0;
         while (conv_busy !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
         end
         cmp({7'h00, n < 400}, 8'h01);
         repeat (3) @(negedge clk);
         rd(slot[i], q);
         cmp(q, 8'ha0 + 8'(i));
         rd(PIO_ADDR_CHAN_SEL, q);
         cmp(q, {4'h0, code[i]});
      end
      $display("t_conv done");
   endtask : t_conv

   task automatic t_result();
      wr(PIO_ADDR_RESULT_LAST, 8'h5a);
      rd(PIO_ADDR_RESULT_LAST, q);
      cmp(q, 8'h5a);
      wr(8'h11, 8'hc3);
      rd(8'h11, q);
      cmp(q, 8'hc3);
      $display("t_result done");
   endtask : t_result

   task automatic t_flag();
      wr(PIO_ADDR_FAULT2, 8'h00);
      repeat (3) @(negedge clk);
      rd(PIO_ADDR_FAULT2, q);
      cmp(q & 8'h80, 8'h00);
      ext = 3'h6;
      repeat (3) @(negedge clk);
      ext = 3'h7;
      repeat (3) @(negedge clk);
      rd(PIO_ADDR_FAULT2, q);
      cmp(q & 8'h80, 8'h80);
      rd(PIO_ADDR_FAULT2, q);
      cmp(q & 8'h80, 8'h80);
      $display("t_flag done");
   endtask : t_flag

   task automatic finish_test();
      $display("Counts: %0d checks, %0d mismatches", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   // Tests take a few hundred cycles; this bound leaves wide margin
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      error_cnt = 0;
      checks_done = 0;
      reset_n = 1'b0;
      large_package = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
      sample_code = 8'h00;
      ext = 3'h7;
      repeat (3) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      t_route();
      t_drive();
      t_level();
      t_conv();
      t_result();
      t_flag();
      finish_test();
   end
endmodule : test_pin_io_and_adc_select_registers
